// File: logic/iqc_map.vh
/*
 Register word indices, field positions, reset values and fixed-point widths
 for the quadrature gain and phase correction block.
 Assumes inclusion by bare name from the design file.
*/
`ifndef IQC_MAP_VH
`define IQC_MAP_VH

`define IQC_FIRST_GAIN_IDX 8'h0c
`define IQC_SECOND_GAIN_IDX 8'h0d
`define IQC_THIRD_GAIN_IDX 8'h0e
`define IQC_DELAY_FOURTH_IDX 8'h0f
`define IQC_DUAL_PHASE_AB_IDX 8'h10
`define IQC_PHASE_CD_IDX 8'h11
`define IQC_SYNC_CTRL_IDX 8'h1e
`define IQC_FIRST_CONFIG_IDX 8'h01

`define IQC_GAIN_W 11
`define IQC_GAIN_HI 10
`define IQC_GAIN_RESET 11'h400
`define IQC_PHASE_W 12
`define IQC_PHASE_HI 11
`define IQC_PHASE_RESET 12'h000
`define IQC_DLY_AB_HI 15
`define IQC_DLY_AB_LO 14
`define IQC_DLY_CD_HI 13
`define IQC_DLY_CD_LO 12
`define IQC_DUAL_HI 13
`define IQC_DUAL_LO 12
`define IQC_DUAL_ON 2'h3
`define IQC_SINGLE_BIT 8
`define IQC_SYNC_BIT 0
`define IQC_SAMPLE_W 16
`define IQC_GAIN_FRAC 10
`define IQC_PHASE_FRAC 12
`define IQC_MAX_DLY 3
`define IQC_RESP_OKAY 2'h0
`define IQC_RESP_SLVERR 2'h2

`endif

// File: logic/iqc_correction.v
/*
 Quadrature gain/phase correction registers and datapath for four
 channels, with staged correction values loaded by an auto-sync write.
 Assumes an AXI4-Lite master on core_clk and synchronous sample inputs.
*/
`timescale 1ns/1ns
`include "iqc_map.vh"

module iqc_correction (
    input wire core_clk,
    input wire reset,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [15:0] sample_a,
    input wire [15:0] sample_b,
    input wire [15:0] sample_c,
    input wire [15:0] sample_d,
    output reg [15:0] out_a,
    output reg [15:0] out_b,
    output reg [15:0] out_c,
    output reg [15:0] out_d,
    output reg dual_mode
);
    // Staging registers, as seen by software
    reg [10:0] first_gain_q;
    reg [10:0] second_gain_q;
    reg [3:0] coarse_mix_q;
    reg [10:0] third_gain_q;
    reg [10:0] fourth_gain_q;
    reg [1:0] dly_ab_q;
    reg [1:0] dly_cd_q;
    reg [1:0] dual_ena_q;
    reg [11:0] phase_ab_q;
    reg [11:0] phase_cd_q;
    reg sync_ena_q;
    reg single_cfg_q;
    // Active correction values
    reg [10:0] act_a_q, act_b_q, act_c_q, act_d_q;
    reg [11:0] act_pab_q, act_pcd_q;

    // Write channel capture, either order
    reg aw_have_q;
    reg w_have_q;
    reg [31:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    wire [31:0] wa = aw_have_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] wd = w_have_q ? wdata_q : s_axi_wdata;
    wire [3:0] ws = w_have_q ? wstrb_q : s_axi_wstrb;
    wire aw_ok = aw_have_q | (s_axi_awvalid & s_axi_awready);
    wire w_ok = w_have_q | (s_axi_wvalid & s_axi_wready);
    wire do_wr = aw_ok & w_ok & ~s_axi_bvalid;
    wire [7:0] widx = wa[9:2];
    // Lower half only: every field sits in bits 15:0
    wire lo_en = ws[0] & ws[1];
    wire map_w = (wa[31:10] == 22'h0) && (wa[1:0] == 2'h0);
    reg w_hit;

    always @*
    begin
        if (!map_w)
            w_hit = 1'b0;
        else if (widx >= `IQC_FIRST_GAIN_IDX && widx <= `IQC_PHASE_CD_IDX)
            w_hit = 1'b1;
        else if (widx == `IQC_SYNC_CTRL_IDX || widx == `IQC_FIRST_CONFIG_IDX)
            w_hit = 1'b1;
        else
            w_hit = 1'b0;
    end

    wire wr_en = do_wr & w_hit & lo_en;
    wire wr_pab = wr_en && (widx == `IQC_DUAL_PHASE_AB_IDX);
    wire wr_pcd = wr_en && (widx == `IQC_PHASE_CD_IDX);

    always @(posedge core_clk)
    begin
        if (reset)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `IQC_RESP_OKAY;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 32'h0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end
        else
        begin
            s_axi_awready <= ~aw_ok & ~s_axi_awready;
            s_axi_wready <= ~w_ok & ~s_axi_wready;
            if (s_axi_awvalid & s_axi_awready & ~do_wr)
            begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready & ~do_wr)
            begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_wr)
            begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= w_hit ? `IQC_RESP_OKAY : `IQC_RESP_SLVERR;
            end
            else if (s_axi_bvalid & s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Register writes; reserved bits are simply never stored
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            first_gain_q <= `IQC_GAIN_RESET;
            second_gain_q <= `IQC_GAIN_RESET;
            coarse_mix_q <= 4'h0;
            third_gain_q <= `IQC_GAIN_RESET;
            fourth_gain_q <= `IQC_GAIN_RESET;
            dly_ab_q <= 2'h0;
            dly_cd_q <= 2'h0;
            dual_ena_q <= 2'h0;
            phase_ab_q <= `IQC_PHASE_RESET;
            phase_cd_q <= `IQC_PHASE_RESET;
            sync_ena_q <= 1'b1;
            single_cfg_q <= 1'b1;
        end
        else if (wr_en)
        begin
            if (widx == `IQC_FIRST_GAIN_IDX)
                first_gain_q <= wd[`IQC_GAIN_HI:0];
            else if (widx == `IQC_SECOND_GAIN_IDX)
            begin
                second_gain_q <= wd[`IQC_GAIN_HI:0];
                coarse_mix_q <= wd[15:12];
            end
            else if (widx == `IQC_THIRD_GAIN_IDX)
                third_gain_q <= wd[`IQC_GAIN_HI:0];
            else if (widx == `IQC_DELAY_FOURTH_IDX)
            begin
                fourth_gain_q <= wd[`IQC_GAIN_HI:0];
                dly_ab_q <= wd[`IQC_DLY_AB_HI:`IQC_DLY_AB_LO];
                dly_cd_q <= wd[`IQC_DLY_CD_HI:`IQC_DLY_CD_LO];
            end
            else if (widx == `IQC_DUAL_PHASE_AB_IDX)
            begin
                phase_ab_q <= wd[`IQC_PHASE_HI:0];
                dual_ena_q <= wd[`IQC_DUAL_HI:`IQC_DUAL_LO];
            end
            else if (widx == `IQC_PHASE_CD_IDX)
                phase_cd_q <= wd[`IQC_PHASE_HI:0];
            else if (widx == `IQC_SYNC_CTRL_IDX)
                sync_ena_q <= wd[`IQC_SYNC_BIT];
            else
                single_cfg_q <= wd[`IQC_SINGLE_BIT];
        end
    end

    // Auto-sync: phase write carries its new value straight in, so the
    // gains of that channel pair written earlier and the phase land together.
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            act_a_q <= `IQC_GAIN_RESET;
            act_b_q <= `IQC_GAIN_RESET;
            act_c_q <= `IQC_GAIN_RESET;
            act_d_q <= `IQC_GAIN_RESET;
            act_pab_q <= `IQC_PHASE_RESET;
            act_pcd_q <= `IQC_PHASE_RESET;
        end
        else
        begin
            if (wr_pab & sync_ena_q)
            begin
                act_a_q <= first_gain_q;
                act_b_q <= second_gain_q;
                act_pab_q <= wd[`IQC_PHASE_HI:0];
            end
            if (wr_pcd & sync_ena_q)
            begin
                act_c_q <= third_gain_q;
                act_d_q <= fourth_gain_q;
                act_pcd_q <= wd[`IQC_PHASE_HI:0];
            end
        end
    end

    // Read channel
    reg [31:0] rd_val;
    reg rd_hit;
    wire [7:0] ridx = s_axi_araddr[9:2];
    wire map_r = (s_axi_araddr[31:10] == 22'h0) && (s_axi_araddr[1:0] == 2'h0);

    always @*
    begin
        rd_val = 32'h0;
        rd_hit = map_r;
        if (!map_r)
            rd_hit = 1'b0;
        else if (ridx == `IQC_FIRST_GAIN_IDX)
            rd_val[`IQC_GAIN_HI:0] = first_gain_q;
        else if (ridx == `IQC_SECOND_GAIN_IDX)
            rd_val[15:0] = {coarse_mix_q, 1'b0, second_gain_q};
        else if (ridx == `IQC_THIRD_GAIN_IDX)
            rd_val[`IQC_GAIN_HI:0] = third_gain_q;
        else if (ridx == `IQC_DELAY_FOURTH_IDX)
            rd_val[15:0] = {dly_ab_q, dly_cd_q, 1'b0, fourth_gain_q};
        else if (ridx == `IQC_DUAL_PHASE_AB_IDX)
            rd_val[15:0] = {2'h0, dual_ena_q, phase_ab_q};
        else if (ridx == `IQC_PHASE_CD_IDX)
            rd_val[`IQC_PHASE_HI:0] = phase_cd_q;
        else if (ridx == `IQC_SYNC_CTRL_IDX)
            rd_val[`IQC_SYNC_BIT] = sync_ena_q;
        else if (ridx == `IQC_FIRST_CONFIG_IDX)
            rd_val[`IQC_SINGLE_BIT] = single_cfg_q;
        else
            rd_hit = 1'b0;
    end

    always @(posedge core_clk)
    begin
        if (reset)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `IQC_RESP_OKAY;
        end
        else if (s_axi_arvalid & s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_hit ? `IQC_RESP_OKAY : `IQC_RESP_SLVERR;
        end
        else if (s_axi_rvalid & s_axi_rready)
            s_axi_rvalid <= 1'b0;
        else if (!s_axi_rvalid)
            s_axi_arready <= s_axi_arvalid & ~s_axi_arready;
    end

    // Datapath: gains in 1.10 format, phase word scaled by 1/4096
    wire signed [27:0] pa = $signed(sample_a) * $signed({1'b0, act_a_q});
    wire signed [27:0] pb = $signed(sample_b) * $signed({1'b0, act_b_q});
    wire signed [27:0] pc = $signed(sample_c) * $signed({1'b0, act_c_q});
    wire signed [27:0] pd = $signed(sample_d) * $signed({1'b0, act_d_q});
    wire signed [27:0] ph_ab = $signed(sample_b) * $signed(act_pab_q);
    wire signed [27:0] ph_cd = $signed(sample_d) * $signed(act_pcd_q);
    // Sum in 1/4096 units before truncation; wraps rather than saturates
    wire signed [29:0] sa = {pa, 2'b00} + {{2{ph_ab[27]}}, ph_ab};
    wire signed [29:0] sc = {pc, 2'b00} + {{2{ph_cd[27]}}, ph_cd};
    wire [15:0] ca = sa[27:12];
    wire [15:0] cb = pb[25:10];
    wire [15:0] cc = sc[27:12];
    wire [15:0] cd = pd[25:10];

    // Delay lines, three taps each; tap 0 is the registered output
    reg [15:0] da_q [0:2];
    reg [15:0] db_q [0:2];
    reg [15:0] dc_q [0:2];
    reg [15:0] dd_q [0:2];
    integer i;

    always @(posedge core_clk)
    begin
        if (reset)
        begin
            for (i = 0; i < `IQC_MAX_DLY; i = i + 1)
            begin
                da_q[i] <= 16'h0;
                db_q[i] <= 16'h0;
                dc_q[i] <= 16'h0;
                dd_q[i] <= 16'h0;
            end
            out_a <= 16'h0;
            out_b <= 16'h0;
            out_c <= 16'h0;
            out_d <= 16'h0;
            dual_mode <= 1'b0;
        end
        else
        begin
            da_q[0] <= ca;
            db_q[0] <= cb;
            dc_q[0] <= cc;
            dd_q[0] <= cd;
            for (i = 1; i < `IQC_MAX_DLY; i = i + 1)
            begin
                da_q[i] <= da_q[i-1];
                db_q[i] <= db_q[i-1];
                dc_q[i] <= dc_q[i-1];
                dd_q[i] <= dd_q[i-1];
            end
            out_a <= (dly_ab_q == 2'h0) ? ca : da_q[dly_ab_q - 2'h1];
            out_b <= (dly_ab_q == 2'h0) ? cb : db_q[dly_ab_q - 2'h1];
            out_c <= (dly_cd_q == 2'h0) ? cc : dc_q[dly_cd_q - 2'h1];
            out_d <= (dly_cd_q == 2'h0) ? cd : dd_q[dly_cd_q - 2'h1];
            dual_mode <= ~single_cfg_q & (dual_ena_q == `IQC_DUAL_ON);
        end
    end
endmodule

// File: test/iqc_correction_properties.sv
/*
 Port checks for the correction block.
 Assumes binding to iqc_correction; reset sync, active high.
*/
`timescale 1ns/1ns

module iqc_checker (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] sample_a,
    input wire logic [15:0] sample_c,
    input wire logic [15:0] out_a,
    input wire logic [15:0] out_c,
    input wire logic dual_mode
);
    logic touched_q;

    // Any write may retune the datapath, so unity checks end there
    always @(posedge core_clk)
    begin
        if (reset)
            touched_q <= 1'b0;
        else if (s_axi_awvalid && s_axi_awready)
            touched_q <= 1'b1;
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    rd_upper_zero_a: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
        else $error("read data upper half set");
    rd_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    wr_answer_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> s_axi_bvalid)
        else $error("write answer late");
    b_single_a: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    r_single_a: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    reset_clear_a: assert property (
        $fell(reset) |-> out_a == 16'h0 && out_c == 16'h0 && !dual_mode)
        else $error("outputs not cleared by reset");
    unity_pass_a: assert property (
        !touched_q && !$past(reset) |->
        out_a == $past(sample_a) && out_c == $past(sample_c))
        else $error("reset settings not transparent");
    dual_idle_a: assert property (
        !touched_q |-> !dual_mode)
        else $error("dual mode without configuration");
endmodule

bind iqc_correction iqc_checker u_chk (
    .core_clk(core_clk), .reset(reset), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .sample_a(sample_a), .sample_c(sample_c), .out_a(out_a),
    .out_c(out_c), .dual_mode(dual_mode));

// File: test/iqc_correction_tb.sv
/*
 Bench for the correction block: bus tasks and scripted tests.
 Assumes the design and its bound checker are compiled first.
*/
`timescale 1ns/1ns

module iqc_correction_tb;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
    logic [31:0] rdata, rval;
    logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
    logic aw_r, w_r, b_v, ar_r, r_v, dual_mode;
    logic [1:0] bresp, rresp, resp;
    logic [15:0] s_a = 16'h0, s_b = 16'h0, s_c = 16'h0, s_d = 16'h0;
    logic [15:0] o_a, o_b, o_c, o_d;
    int cyc = 0, error_cnt = 0, total_checks = 0;

    iqc_correction u_dut (
        .core_clk(core_clk), .reset(reset), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
        .s_axi_bresp(bresp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
        .s_axi_araddr(araddr), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(r_v),
        .s_axi_rready(r_r), .sample_a(s_a), .sample_b(s_b), .sample_c(s_c),
        .sample_d(s_d), .out_a(o_a), .out_b(o_b), .out_c(o_c), .out_d(o_d),
        .dual_mode(dual_mode));

    always #50 core_clk = ~core_clk;

    // Ramps stay positive so any past sample can be recomputed
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        s_a <= 16'((cyc + 1) * 4);
        s_b <= 16'((cyc + 1) * 8);
        s_c <= 16'((cyc + 1) * 4);
        s_d <= 16'((cyc + 1) * 8);
    end

    task automatic chk(input [31:0] seen, input [31:0] exp, input string n);
    begin
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    end
    endtask

    task automatic bus_wr(input [31:0] a, input [31:0] d);
        logic aw_ok, w_ok;
    begin
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        b_r <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge core_clk);
            if (aw_r === 1'b1)
            begin
                aw_ok = 1'b1;
                aw_v <= 1'b0;
            end
            if (w_r === 1'b1)
            begin
                w_ok = 1'b1;
                w_v <= 1'b0;
            end
        end
        do
            @(posedge core_clk);
        while (b_v !== 1'b1);
        resp = bresp;
        b_r <= 1'b0;
    end
    endtask

    task automatic bus_rd(input [31:0] a);
    begin
        @(posedge core_clk);
        araddr <= a;
        ar_v <= 1'b1;
        r_r <= 1'b1;
        do
            @(posedge core_clk);
        while (ar_r !== 1'b1);
        ar_v <= 1'b0;
        do
            @(posedge core_clk);
        while (r_v !== 1'b1);
        rval = rdata;
        resp = rresp;
        r_r <= 1'b0;
    end
    endtask

    task automatic rchk(input [31:0] a, input [31:0] e);
    begin
        bus_rd(a);
        chk(rval, e, "rdata");
    end
    endtask

    // Waits out any delay change before comparing with the ramps
    task automatic ochk(input int da, input int dc, input int ka, input int kc);
    begin
        repeat (5) @(posedge core_clk);
        chk(o_a, {16'h0, 16'((cyc - 1 - da) * ka)}, "out_a");
        chk(o_b, {16'h0, 16'((cyc - 1 - da) * 8)}, "out_b");
        chk(o_c, {16'h0, 16'((cyc - 1 - dc) * kc)}, "out_c");
        chk(o_d, {16'h0, 16'((cyc - 1 - dc) * 8)}, "out_d");
    end
    endtask

    task automatic dchk(input logic e);
    begin
        repeat (2) @(posedge core_clk);
        chk(dual_mode, e, "dual_mode");
    end
    endtask

    task automatic report_and_stop;
    begin
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask

    initial
    begin
        repeat (3000) @(posedge core_clk);
        error_cnt++;
        report_and_stop();
    end

    initial
    begin
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        rchk(32'h30, 32'h400);
        chk(resp, 2'h0, "rresp");
        rchk(32'h38, 32'h400);
        rchk(32'h3c, 32'h400);
        rchk(32'h40, 32'h0);
        ochk(0, 0, 4, 4);
        $display("reset values done");
        bus_wr(32'h38, 32'hffffffff);
        chk(resp, 2'h0, "bresp");
        rchk(32'h38, 32'h7ff);
        bus_wr(32'h100, 32'h1);
        chk(resp, 2'h2, "bresp");
        bus_rd(32'h100);
        chk(resp, 2'h2, "rresp");
        bus_wr(32'h38, 32'h400);
        $display("access done");
        bus_wr(32'h3c, 32'hfffffc00);
        rchk(32'h3c, 32'hf400);
        ochk(3, 3, 4, 4);
        bus_wr(32'h3c, 32'h9400);
        ochk(2, 1, 4, 4);
        bus_wr(32'h3c, 32'h400);
        $display("delays done");
        bus_wr(32'h30, 32'h200);
        bus_wr(32'h34, 32'h400);
        ochk(0, 0, 4, 4);
        rchk(32'h30, 32'h200);
        bus_wr(32'h40, 32'h600);
        ochk(0, 0, 5, 4);
        bus_wr(32'h38, 32'h200);
        bus_wr(32'h44, 32'h600);
        ochk(0, 0, 5, 5);
        bus_wr(32'h40, 32'ha00);
        ochk(0, 0, -1, 5);
        $display("correction done");
        bus_wr(32'h40, 32'h3a00);
        dchk(1'b0);
        bus_wr(32'h04, 32'h0);
        dchk(1'b1);
        bus_wr(32'h78, 32'h0);
        bus_wr(32'h30, 32'h400);
        bus_wr(32'h40, 32'h3000);
        ochk(0, 0, -1, 5);
        $display("dual and sync done");
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        rchk(32'h40, 32'h0);
        ochk(0, 0, 4, 4);
        $display("second reset done");
        report_and_stop();
    end
endmodule
